// >>> rtl/sdc_defines.svh
// Constants for the command and state decoder
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH
`define SDC_MODE_DELAY_CYC 2
`define SDC_LAT_LSB 4
`define SDC_LAT_MSB 6
`define SDC_BL_MSB 2
`define SDC_MODE_RESET 12'h020
`define SDC_REFRESH_CYC 4
`endif

// >>> rtl/sdc_pkg.sv
// Types for the command and state decoder
package sdc_pkg;
  typedef enum logic [1:0] {SDC_RUN, SDC_SUSPEND, SDC_POWER_DOWN, SDC_SELF_REFRESH} sdc_power_t;
  typedef enum logic [2:0] {SDC_IDLE, SDC_ROW_ACTIVE, SDC_READ, SDC_WRITE, SDC_PRECHARGE,
                            SDC_REFRESH} sdc_bank_t;
  typedef struct packed {
    sdc_power_t  power;
    sdc_bank_t   state;
    logic [1:0]  bank_open;
    logic        bank;
    logic [7:0]  column;
    logic [3:0]  burst_left;
    logic [11:0] mode;
    logic [1:0]  mode_wait;
    logic [2:0]  refresh_cnt;
    logic [7:0]  rd_valid_pipe;
    logic        cke_prev;
    logic        dout_en_upper;
    logic        dout_en_lower;
    logic        wr_upper;
    logic        wr_lower;
    logic [8:0]  rd_addr;
    logic [17:0] rd_addr_pipe;
    logic        rd_valid;
    logic        power_down;
    logic        suspended;
    logic        self_refresh;
  } sdc_state_t;
endpackage

// >>> rtl/sdc_decoder.sv
// Command decoder and state tracker for the two-bank synchronous memory
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defines.svh"
module sdc_decoder
  import sdc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       cke,
  input  wire logic       cs_n,
  input  wire logic       ras_n,
  input  wire logic       cas_n,
  input  wire logic       we_n,
  input  wire logic       byte_mask_upper,
  input  wire logic       byte_mask_lower,
  input  wire logic       bank_select_bit,
  input  wire logic       auto_precharge_bit,
  input  wire logic [9:0] addr_low,
  output logic            upper_lane_enable,
  output logic            lower_lane_enable,
  output logic            write_upper,
  output logic            write_lower,
  output logic [8:0]      read_addr,
  output logic            read_data_valid,
  output logic [1:0]      bank_active,
  output logic            power_down,
  output logic            suspended,
  output logic            self_refresh
);
  sdc_state_t q;
  sdc_state_t d;
  logic [1:0] cke_sync;
  logic [1:0] lane_meta;
  logic [4:0] cmd_meta;
  logic [11:0] addr_meta;
  logic [1:0] lane_sync;
  logic [4:0] cmd_sync;
  logic [11:0] addr_sync;
  logic       cke_now;
  logic       sel;
  logic       is_nop;
  logic       is_halt;
  logic       is_read;
  logic       is_write;
  logic       is_pre;
  logic       is_act;
  logic       is_ref;
  logic       is_mode;
  logic [3:0] burst_len;
  logic [2:0] lat;

  function automatic logic [3:0] burst_of(input logic [11:0] m);
    unique case (m[`SDC_BL_MSB:0])
      3'h0:    burst_of = 4'h1;
      3'h1:    burst_of = 4'h2;
      3'h2:    burst_of = 4'h4;
      default: burst_of = 4'h8;
    endcase
  endfunction

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cke_sync  <= 2'h0;
      lane_meta <= 2'h3;
      cmd_meta  <= 5'h1f;
      addr_meta <= 12'h000;
      lane_sync <= 2'h3;
      cmd_sync  <= 5'h1f;
      addr_sync <= 12'h000;
    end
    else
    begin
      cke_sync  <= {cke_sync[0], cke};
      lane_meta <= {byte_mask_upper, byte_mask_lower};
      cmd_meta  <= {cs_n, ras_n, cas_n, we_n, 1'b0};
      addr_meta <= {bank_select_bit, auto_precharge_bit, addr_low};
      lane_sync <= lane_meta;
      cmd_sync  <= cmd_meta;
      addr_sync <= addr_meta;
    end
  end

  assign cke_now   = cke_sync[1];
  assign sel       = ~cmd_sync[4];
  assign is_nop    = ~sel | (cmd_sync[3:1] == 3'h7);
  assign is_halt   = sel & (cmd_sync[3:1] == 3'h6);
  assign is_read   = sel & (cmd_sync[3:1] == 3'h5);
  assign is_write  = sel & (cmd_sync[3:1] == 3'h4);
  assign is_act    = sel & (cmd_sync[3:1] == 3'h3);
  assign is_pre    = sel & (cmd_sync[3:1] == 3'h2);
  assign is_ref    = sel & (cmd_sync[3:1] == 3'h1);
  assign is_mode   = sel & (cmd_sync[3:1] == 3'h0);
  assign burst_len = burst_of(q.mode);
  assign lat       = q.mode[`SDC_LAT_MSB:`SDC_LAT_LSB];

  always_comb
  begin
    d = q;
    d.cke_prev = cke_now;
    d.rd_valid_pipe = {q.rd_valid_pipe[6:0], 1'b0};
    d.rd_addr_pipe = {q.rd_addr_pipe[8:0], q.bank, q.column};
    d.wr_upper = 1'b0;
    d.wr_lower = 1'b0;
    if (q.mode_wait != 2'h0)
      d.mode_wait = q.mode_wait - 2'h1;
    if (!q.cke_prev)
    begin
      if (cke_now)
        d.power = SDC_RUN;
    end
    else if (!cke_now && q.state != SDC_IDLE && q.state != SDC_REFRESH)
      d.power = SDC_SUSPEND;
    else
    begin
      d.dout_en_upper = ~lane_sync[1];
      d.dout_en_lower = ~lane_sync[0];
      if (q.state == SDC_READ && q.burst_left != 4'h0)
      begin
        d.burst_left = q.burst_left - 4'h1;
        d.column = q.column + 8'h01;
        d.rd_valid_pipe[0] = 1'b1;
        if (q.burst_left == 4'h1)
          d.state = SDC_ROW_ACTIVE;
      end
      if (q.state == SDC_WRITE && q.burst_left != 4'h0)
      begin
        d.burst_left = q.burst_left - 4'h1;
        d.column = q.column + 8'h01;
        d.wr_upper = ~lane_sync[1];
        d.wr_lower = ~lane_sync[0];
        if (q.burst_left == 4'h1)
          d.state = SDC_ROW_ACTIVE;
      end
      if (q.state == SDC_PRECHARGE || q.state == SDC_REFRESH)
      begin
        if (q.refresh_cnt != 3'h0)
          d.refresh_cnt = q.refresh_cnt - 3'h1;
        else
          d.state = (q.bank_open != 2'h0) ? SDC_ROW_ACTIVE : SDC_IDLE;
      end
      unique case (q.state)
        SDC_IDLE:
        begin
          if ((is_nop || is_halt) && !cke_now)
            d.power = SDC_POWER_DOWN;
          else if (is_act)
          begin
            d.bank_open[addr_sync[11]] = 1'b1;
            d.state = SDC_ROW_ACTIVE;
          end
          else if (is_ref)
          begin
            d.refresh_cnt = 3'(`SDC_REFRESH_CYC);
            d.state = SDC_REFRESH;
            if (!cke_now)
              d.power = SDC_SELF_REFRESH;
          end
          else if (is_mode)
          begin
            d.mode = addr_sync;
            d.mode_wait = 2'(`SDC_MODE_DELAY_CYC);
          end
        end
        SDC_ROW_ACTIVE, SDC_READ:
        begin
          if (is_halt && q.state == SDC_READ)
          begin
            d.burst_left = 4'h0;
            d.state = SDC_ROW_ACTIVE;
          end
          else if ((is_read || is_write) && q.bank_open[addr_sync[11]])
          begin
            d.state = is_read ? SDC_READ : SDC_WRITE;
            d.bank = addr_sync[11];
            d.column = addr_sync[7:0];
            d.burst_left = burst_len;
          end
          else if (is_act)
            d.bank_open[addr_sync[11]] = 1'b1;
          else if (is_pre)
          begin
            if (addr_sync[10])
              d.bank_open = 2'h0;
            else
              d.bank_open[addr_sync[11]] = 1'b0;
            d.burst_left = 4'h0;
            d.refresh_cnt = 3'h1;
            d.state = SDC_PRECHARGE;
          end
        end
        default:
        begin
        end
      endcase
    end
    d.rd_valid = (lat == 3'h3) ? q.rd_valid_pipe[1] : q.rd_valid_pipe[0];
    if (d.rd_valid)
      d.rd_addr = (lat == 3'h3) ? q.rd_addr_pipe[17:9] : q.rd_addr_pipe[8:0];
    d.power_down = (d.power == SDC_POWER_DOWN);
    d.suspended = (d.power == SDC_SUSPEND);
    d.self_refresh = (d.power == SDC_SELF_REFRESH);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.mode <= `SDC_MODE_RESET;
      q.dout_en_upper <= 1'b0;
      q.dout_en_lower <= 1'b0;
    end
    else
      q <= d;
  end

  assign upper_lane_enable = q.dout_en_upper;
  assign lower_lane_enable = q.dout_en_lower;
  assign write_upper       = q.wr_upper;
  assign write_lower       = q.wr_lower;
  assign read_addr         = q.rd_addr;
  assign read_data_valid   = q.rd_valid;
  assign bank_active       = q.bank_open;
  assign power_down        = q.power_down;
  assign suspended         = q.suspended;
  assign self_refresh      = q.self_refresh;

  a_suspend_entry: assert property (@(posedge clk) disable iff (!reset_n)
    (q.cke_prev && !cke_now && q.state == SDC_READ) |=> q.suspended)
    else $error("suspend not entered");
  a_frozen_state: assert property (@(posedge clk) disable iff (!reset_n)
    (!q.cke_prev && q.power == SDC_SUSPEND) |=> $stable(q.state))
    else $error("state moved in suspend");
  a_halt_read: assert property (@(posedge clk) disable iff (!reset_n)
    (q.cke_prev && cke_now && q.state == SDC_READ && is_halt) |=> q.state == SDC_ROW_ACTIVE)
    else $error("halt ignored");
  a_pre_all: assert property (@(posedge clk) disable iff (!reset_n)
    (q.cke_prev && cke_now && q.state == SDC_ROW_ACTIVE && is_pre && addr_sync[10])
    |=> bank_active == 2'h0)
    else $error("banks left open");
  a_mask_write: assert property (@(posedge clk) disable iff (!reset_n)
    (q.cke_prev && cke_now && lane_sync[1]) |=> !write_upper)
    else $error("masked upper lane written");
  a_mask_lower: assert property (@(posedge clk) disable iff (!reset_n)
    (q.cke_prev && cke_now && lane_sync[0]) |=> !lower_lane_enable && !write_lower)
    else $error("lower lane not blocked");
  a_enable_upper: assert property (@(posedge clk) disable iff (!reset_n)
    (q.cke_prev && cke_now && !lane_sync[1] && !q.suspended) |=> upper_lane_enable)
    else $error("upper lane not enabled");
  a_power_down: assert property (@(posedge clk) disable iff (!reset_n)
    (q.cke_prev && !cke_now && q.state == SDC_IDLE && is_nop) |=> power_down)
    else $error("power-down missed");
  a_resume: assert property (@(posedge clk) disable iff (!reset_n)
    (q.suspended && !q.cke_prev && cke_now) |=> !suspended)
    else $error("suspend not left");
  a_read_lat: assert property (@(posedge clk) disable iff (!reset_n)
    (q.rd_valid_pipe[0] && lat != 3'h3) |=> read_data_valid)
    else $error("read data late");

  c_read_burst: cover property (@(posedge clk) disable iff (!reset_n) q.state == SDC_READ ##1
    q.state == SDC_ROW_ACTIVE);
  c_suspend: cover property (@(posedge clk) disable iff (!reset_n) suspended ##1 !suspended);
  c_power_down: cover property (@(posedge clk) disable iff (!reset_n) power_down);
  c_read_to_write: cover property (@(posedge clk) disable iff (!reset_n) q.state == SDC_READ ##1
    q.state == SDC_WRITE);
endmodule // sdc_decoder
`default_nettype wire

// >>> dv/sdc_ctrl_model.sv
// Memory controller model issuing commands to the decoder
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_model (
  input  wire logic  clk,
  output logic       cke,
  output logic       cs_n,
  output logic       ras_n,
  output logic       cas_n,
  output logic       we_n,
  output logic       bsel,
  output logic       ap,
  output logic [9:0] addr
);
  initial {cke, cs_n, ras_n, cas_n, we_n, bsel, ap, addr} = {5'h1f, 12'h000};
  // Deselect cycles, unused pins other than bsel and ap keep changing
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge clk);
      #2;
      cs_n = 1'b1;
      {ras_n, cas_n, we_n, addr} = ~{ras_n, cas_n, we_n, addr};
    end
  endtask
  // One command cycle, plus two deselect cycles after a mode load; gate level held after
  task automatic cmd(input logic [3:0] c, input logic [11:0] a, input logic ck);
    @(posedge clk);
    #2;
    {cs_n, ras_n, cas_n, we_n} = c;
    {bsel, ap, addr} = a;
    cke = ck;
    if (c == 4'b0000)
      idle(2);
  endtask
endmodule // sdc_ctrl_model
`default_nettype wire

// >>> dv/sdc_decoder_test.sv
// Self-checking bench for the command decoder
`timescale 1ns/1ps
`default_nettype none
module sdc_decoder_test;
  localparam logic [3:0] NOP = 4'b0111, ACT = 4'b0011, RD = 4'b0101, WR = 4'b0100;
  localparam logic [3:0] PRE = 4'b0010, HALT = 4'b0110, REF = 4'b0001, MODE_LOAD_CMD = 4'b0000;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        mu = 1'b0;
  logic        ml = 1'b0;
  logic        skip = 1'b1;
  logic        cke, cs_n, ras_n, cas_n, we_n, bsel, ap, ue, le, wu, wl, rv, pd, su, sr;
  logic [9:0]  addr;
  logic [8:0]  ra, last_addr;
  logic [1:0]  ba;
  logic [7:0]  rnd = 8'h42;
  logic [10:0] rq[$];
  logic [1:0]  wq[$];
  int          fail_count = 0;
  int          tests_run = 0;
  int          beats = 0;

  always #20 clk = ~clk;

  sdc_ctrl_model ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bsel(bsel), .ap(ap), .addr(addr));
  sdc_decoder dut (.clk(clk), .reset_n(reset_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .byte_mask_upper(mu), .byte_mask_lower(ml),
    .bank_select_bit(bsel), .auto_precharge_bit(ap), .addr_low(addr),
    .upper_lane_enable(ue), .lower_lane_enable(le), .write_upper(wu), .write_lower(wl),
    .read_addr(ra), .read_data_valid(rv), .bank_active(ba), .power_down(pd),
    .suspended(su), .self_refresh(sr));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Beat watcher, settled outputs
  always @(negedge clk)
  begin
    if (rv === 1'b1)
    begin
      last_addr = ra;
      beats++;
      if (!skip)
        check("read beat", {ra, ue, le}, rq.size() ? rq.pop_front() : 11'h7ff);
    end
    if (wu === 1'b1 || wl === 1'b1)
      check("write beat", 11'({wu, wl}), wq.size() ? 11'(wq.pop_front()) : 11'h0);
  end

  initial
  begin
    #(40 * 2000);
    fail_count++;
    $display("FAIL watchdog expected done seen hang");
    stop_test();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    #2;
    reset_n = 1'b1;
    check("reset", 11'({ue, le, wu, wl, rv, pd, su, sr, ba}), 11'h0);
    ctl.idle(3);
    ctl.cmd(MODE_LOAD_CMD, 12'h023, 1'b1);
    ctl.cmd(ACT, 12'h000, 1'b1);
    ctl.cmd(ACT, 12'h800, 1'b1);
    ctl.idle(6);
    check("both open", 11'(ba), 11'h3);
    ctl.cmd(PRE, 12'h800, 1'b1);
    ctl.idle(6);
    check("one closed", 11'(ba), 11'h1);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      {mu, ml} = 2'(i) ^ rnd[1:0];
      skip = 1'b0;
      for (int j = 0; j < 8; j++)
      begin
        rq.push_back({1'b0, 8'(8 + j), ~mu, ~ml});
        if (!(mu && ml))
          wq.push_back({~mu, ~ml});
      end
      ctl.cmd(RD, 12'h008, 1'b1);
      ctl.idle(16);
      check("row kept", 11'(ba), 11'h1);
      skip = 1'b1;
      ctl.cmd(RD, 12'h040, 1'b1);
      ctl.cmd(WR, 12'h020, 1'b1);
      ctl.idle(16);
      check("queues empty", 11'(rq.size() + wq.size()), 11'h0);
    end
    ctl.cmd(RD, 12'h040, 1'b1);
    ctl.cmd(RD, 12'h080, 1'b1);
    ctl.idle(16);
    check("restart end", 11'(last_addr), 11'h087);
    beats = 0;
    ctl.cmd(RD, 12'h000, 1'b1);
    ctl.idle(2);
    ctl.cmd(HALT, 12'h000, 1'b1);
    ctl.idle(16);
    check("halted", 11'({beats < 8, ba}), 11'h5);
    ctl.cmd(PRE, 12'h400, 1'b0);
    ctl.idle(6);
    check("suspend", 11'({su, ba}), 11'h5);
    ctl.cmd(NOP, 12'h000, 1'b1);
    ctl.idle(6);
    check("resume", 11'({su, ba}), 11'h1);
    ctl.cmd(RD, 12'h010, 1'b1);
    ctl.cmd(PRE, 12'h400, 1'b1);
    ctl.idle(6);
    check("read closed", 11'(ba), 11'h0);
    ctl.cmd(NOP, 12'h000, 1'b0);
    ctl.idle(6);
    check("power down", 11'({pd, sr}), 11'h2);
    ctl.cmd(NOP, 12'h000, 1'b1);
    ctl.idle(6);
    ctl.cmd(REF, 12'h000, 1'b0);
    ctl.idle(6);
    check("self refresh", 11'({pd, sr}), 11'h1);
    ctl.cmd(NOP, 12'h000, 1'b1);
    ctl.idle(6);
    check("awake", 11'({pd, sr, su}), 11'h0);
    stop_test();
  end
endmodule // sdc_decoder_test
`default_nettype wire
